// [src/mcfg_gap_timer.sv]
module mcfg_gap_timer
	import mcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Nibble time enable
	input wire logic nib_tick,
	// Gap setting
	input wire logic [6:0] gap_field,
	input wire logic full_duplex,
	// Transmit sequencing
	input wire logic tx_end,
	output logic gap_busy,
	output logic [7:0] gap_nibbles
);
	logic [7:0] left_reg;
	logic [7:0] left_next;
	logic [7:0] total;

	always_comb
	begin
		total = {1'b0, gap_field} + (full_duplex ? GAP_ADD_FDX : GAP_ADD_HDX); // [R3] [R4]
		left_next = left_reg;
		if (tx_end)
			left_next = total; // [R2]
		else if (nib_tick && left_reg != 8'h00)
			left_next = left_reg - 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			left_reg <= 8'h00;
		else
			left_reg <= left_next;
	end

	assign gap_busy = (left_reg != 8'h00);
	assign gap_nibbles = total;
endmodule

// [src/mcfg_nibble_tick.sv]
module mcfg_nibble_tick
	import mcfg_pkg::*;
#(
	parameter int CYCLES = NIBBLE_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tick out
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	// A zero-length nibble would never produce a tick
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("mcfg_nibble_tick: CYCLES must be at least 1");
	end

	always_comb
	begin
		cnt_next = cnt_reg + 1'b1;
		tick_next = 1'b0;
		if (cnt_reg == CW'(CYCLES - 1))
		begin
			cnt_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// [src/mcfg_pkg.sv]
package mcfg_pkg;
	// Register word offsets on the Avalon-MM slave (byte addresses)
	localparam logic [4:0] ADDR_GAP = 5'h00;
	localparam logic [4:0] ADDR_MAC3 = 5'h04;
	localparam logic [4:0] ADDR_PHY1 = 5'h08;
	localparam logic [4:0] ADDR_PHY2 = 5'h0c;
	localparam logic [3:0] ADDR_LED = 4'h0;
	localparam logic [3:0] ADDR_LED_B = 4'h0;
	localparam logic [4:0] ADDR_LEDS = 5'h10;
	localparam logic [4:0] ADDR_STAT = 5'h14;
	localparam logic [4:0] ADDR_STRAP = 5'h18;

	// Field positions
	localparam int GAP_W = 7;
	localparam int MAC3_FDX_BIT = 0;
	localparam int PHY1_LOOP_BIT = 14;
	localparam int PHY1_DPX_BIT = 8;
	localparam int PHY2_FORCE_LINK_UP_BIT = 14;
	localparam int PHY2_TXOFF_BIT = 13;
	localparam int PHY2_JABOFF_BIT = 10;
	localparam int PHY2_HDLOFF_BIT = 8;

	// Writable mask of control register 2; reserved bits are kept zero
	localparam logic [15:0] PHY2_WMASK = 16'h6500;
	localparam logic [15:0] PHY1_WMASK = 16'h4100;

	// Reset values
	localparam logic [6:0] GAP_RST = 7'h00;
	localparam logic [15:0] LED_RST = 16'h0000;

	// Gap offsets in nibble times
	localparam logic [7:0] GAP_ADD_FDX = 8'h03;
	localparam logic [7:0] GAP_ADD_HDX = 8'h06;
	localparam logic [6:0] GAP_REC_FDX = 7'h15;
	localparam logic [6:0] GAP_REC_HDX = 7'h12;

	// One nibble time at 10 Mb/s is 400 ns
	localparam int CLK_MHZ = 25;
	localparam int NIBBLE_NS = 400;
	localparam int NIBBLE_CYC = (NIBBLE_NS * CLK_MHZ + 999) / 1000;
endpackage

// [src/mcfg_top.sv]
// Behaviour
// R1 - Gap register top bit reads zero
// R2 - Back-to-back gap delay in nibble times
// R3 - Full duplex gap is field plus three
// R4 - Half duplex gap is field plus six
// R5 - PHY duplex bit sets duplex, strap-initialised; here full_duplex is set only when the MAC duplex bit is also set
// R6 - Host rewrites duplex bit if strap wrong
// R7 - Host may copy PHY duplex to MAC
// R8 - Host keeps both duplex bits equal
// R9 - Host may disable half-duplex loopback
// R10 - Loopback disable only when duplex, loopback zero
// R11 - LED register drives both LED outputs
// R12 - Disable routes transmit to twisted pair only
// R13 - Control two bits reset normal, reserved zero
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module mcfg_top
	import mcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Duplex strap pin
	input wire logic strap_duplex,
	// Transmit sequencing
	input wire logic tx_end,
	output logic tx_gap_busy,
	// PHY controls
	output logic full_duplex,
	output logic tx_loopback,
	output logic tx_to_pair,
	output logic force_link_up,
	output logic twisted_pair_tx_disable,
	output logic correction_disable_a,
	// LEDs
	output logic led_output_first,
	output logic led_output_second
);
	logic strap_s1_reg;
	logic strap_s2_reg;
	logic [1:0] strap_cnt_reg;
	logic [1:0] strap_cnt_next;
	logic wait_reg;
	logic [6:0] gap_reg;
	logic [6:0] gap_next;
	logic mac_fdx_reg;
	logic mac_fdx_next;
	logic [15:0] phy1_reg;
	logic [15:0] phy1_next;
	logic [15:0] phy2_reg;
	logic [15:0] phy2_next;
	logic [15:0] led_reg;
	logic [15:0] led_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic ack_next;
	logic [7:0] out_reg;
	logic [7:0] out_next;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic nib_tick;
	logic gap_busy;
	logic [7:0] gap_nibbles;
	logic hd_loop_off;

	// Strap crosses in from a pin
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
		end
		else
		begin
			strap_s1_reg <= strap_duplex;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	mcfg_nibble_tick #(
		.CYCLES(NIBBLE_CYC)
	) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick(nib_tick)
	);

	mcfg_gap_timer u_gap (
		.clk(clk),
		.rst_n(rst_n),
		.nib_tick(nib_tick),
		.gap_field(gap_reg),
		.full_duplex(mac_fdx_reg),
		.tx_end(tx_end),
		.gap_busy(gap_busy),
		.gap_nibbles(gap_nibbles)
	);

	// Byte-enable mask and merged write data
	always_comb
	begin
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wval = avs_writedata & wmask;
	end

	always_comb
	begin
		gap_next = gap_reg;
		mac_fdx_next = mac_fdx_reg;
		phy1_next = phy1_reg;
		phy2_next = phy2_reg;
		led_next = led_reg;
		strap_cnt_next = strap_cnt_reg;
		rdata_next = rdata_reg;
		ack_next = 1'b0;
		// Strap loads the duplex bit on each of the first three cycles out of reset
		// Three loads, so the last one sees the pin through both stages
		if (strap_cnt_reg != 2'h3)
		begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
			phy1_next[PHY1_DPX_BIT] = strap_s2_reg; // [R5]
		end
		if ((avs_read || avs_write) && !ack_reg)
		begin
			ack_next = 1'b1;
			rdata_next = 32'h0000_0000;
			if (avs_write)
			begin
				case (avs_address)
					ADDR_GAP:
					begin
						if (avs_byteenable[0])
							gap_next = wval[6:0]; // [R2]
					end
					ADDR_MAC3:
					begin
						if (avs_byteenable[0])
							mac_fdx_next = wval[MAC3_FDX_BIT]; // [R7]
					end
					ADDR_PHY1:
					begin
						// Host write overrides a missing strap
						phy1_next = (phy1_reg & ~(PHY1_WMASK & wmask[15:0]))
							| (wval[15:0] & PHY1_WMASK); // [R6]
					end
					ADDR_PHY2:
					begin
						phy2_next = (phy2_reg & ~(PHY2_WMASK & wmask[15:0]))
							| (wval[15:0] & PHY2_WMASK); // [R13]
					end
					ADDR_LEDS:
					begin
						led_next = (led_reg & ~wmask[15:0])
							| wval[15:0]; // [R11]
					end
					default:
					begin
						gap_next = gap_reg;
					end
				endcase
			end
			else
			begin
				case (avs_address)
					ADDR_GAP:
						rdata_next = {25'h0, gap_reg}; // [R1]
					ADDR_MAC3:
						rdata_next = {31'h0, mac_fdx_reg};
					ADDR_PHY1:
						rdata_next = {16'h0, phy1_reg};
					ADDR_PHY2:
						rdata_next = {16'h0, phy2_reg};
					ADDR_LEDS:
						rdata_next = {16'h0, led_reg};
					ADDR_STAT:
						rdata_next = {22'h0, gap_busy,
							(phy1_reg[PHY1_DPX_BIT] == mac_fdx_reg), gap_nibbles};
					ADDR_STRAP:
						rdata_next = {31'h0, strap_s2_reg};
					default:
						rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			gap_reg <= GAP_RST;
			mac_fdx_reg <= 1'b0;
			phy1_reg <= 16'h0000;
			phy2_reg <= 16'h0000;
			led_reg <= LED_RST;
			strap_cnt_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
			wait_reg <= 1'b1;
		end
		else
		begin
			gap_reg <= gap_next;
			mac_fdx_reg <= mac_fdx_next;
			phy1_reg <= phy1_next;
			phy2_reg <= phy2_next;
			led_reg <= led_next;
			strap_cnt_reg <= strap_cnt_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			wait_reg <= !ack_next;
		end
	end

	// Duplex and loopback routing
	always_comb
	begin
		hd_loop_off = phy2_reg[PHY2_HDLOFF_BIT]
			&& !phy1_reg[PHY1_DPX_BIT]
			&& !phy1_reg[PHY1_LOOP_BIT]; // [R10]
		out_next[0] = phy1_reg[PHY1_DPX_BIT] & mac_fdx_reg; // [R5] [R8]
		// Half duplex loops back unless disabled; internal loopback always does
		out_next[1] = phy1_reg[PHY1_LOOP_BIT]
			|| (!phy1_reg[PHY1_DPX_BIT] && !hd_loop_off); // [R12] [R9]
		out_next[2] = !phy1_reg[PHY1_LOOP_BIT]
			&& !phy2_reg[PHY2_TXOFF_BIT]; // [R12]
		out_next[3] = phy2_reg[PHY2_FORCE_LINK_UP_BIT]; // [R13]
		out_next[4] = phy2_reg[PHY2_TXOFF_BIT];
		out_next[5] = phy2_reg[PHY2_JABOFF_BIT];
		out_next[6] = led_reg[0]; // [R11]
		out_next[7] = led_reg[1]; // [R11]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			out_reg <= 8'h00;
		else
			out_reg <= out_next;
	end

	logic busy_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			busy_reg <= 1'b0;
		else
			busy_reg <= gap_busy;
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign tx_gap_busy = busy_reg;
	assign full_duplex = out_reg[0];
	assign tx_loopback = out_reg[1];
	assign tx_to_pair = out_reg[2];
	assign force_link_up = out_reg[3];
	assign twisted_pair_tx_disable = out_reg[4];
	assign correction_disable_a = out_reg[5];
	assign led_output_first = out_reg[6];
	assign led_output_second = out_reg[7];
endmodule

// [testbench/mcfg_host.sv]
module mcfg_host
(
	// Clock
	input wire logic clk,
	// Avalon-MM master
	input wire logic avs_waitrequest,
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do
			@(posedge clk);
		while (avs_waitrequest);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Stale data is scrambled so no one leans on it
		avs_writedata <= ~d;
		@(posedge clk);
	endtask
endmodule

// [testbench/mcfg_top_chk.sv]
module mcfg_top_chk
	import mcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Gap and PHY
	input wire logic tx_end,
	input wire logic tx_gap_busy,
	input wire logic tx_to_pair,
	input wire logic force_link_up,
	input wire logic twisted_pair_tx_disable,
	// LEDs
	input wire logic led_output_first,
	input wire logic led_output_second
);
	logic rdy;
	logic [10:0] run_reg;
	logic [10:0] run_next;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	assign rdy = avs_read && !avs_waitrequest;
	// Tick phase is free, so the low bound is one nibble loose
	always_comb run_next = tx_gap_busy ? run_reg + 11'h1 : 11'h0;
	always_ff @(posedge clk) run_reg <= rst_n ? run_next : 11'h0;
	sequence busy_s;
		##[1:2] tx_gap_busy;
	endsequence
	gap_top_a: assert property (rdy && avs_address == 5'h00
		|-> avs_readdata[31:7] == 25'h0) else $error("gap bit 7 set");
	ctl2_resv_a: assert property (rdy && avs_address == 5'h0c
		|-> (avs_readdata & ~{16'h0, PHY2_WMASK}) == 32'h0)
		else $error("reserved bit set");
	rst_out_a: assert property ($rose(rst_n) |-> avs_waitrequest
		&& !force_link_up && !twisted_pair_tx_disable)
		else $error("bad reset value");
	pair_cut_a: assert property (twisted_pair_tx_disable[*2]
		|-> !tx_to_pair) else $error("pair on while off");
	gap_start_a: assert property ($rose(tx_end) |-> busy_s)
		else $error("gap not started");
	gap_min_a: assert property ($fell(tx_gap_busy)
		|-> run_reg >= 11'h014) else $error("gap short");
	gap_max_a: assert property (tx_gap_busy
		|-> run_reg < 11'h541) else $error("gap long");
	led_write_a: assert property ($changed({led_output_first,
		led_output_second}) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("led moved alone");
endmodule
bind mcfg_top mcfg_top_chk mcfg_top_chk_inst(.*);

// [testbench/mcfg_top_tb.sv]
module mcfg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, strap_duplex = 1'b1, tx_end = 1'b0;
	logic obs_p = 1'b0, avs_read, avs_write, avs_waitrequest, tx_gap_busy;
	logic full_duplex, tx_loopback, tx_to_pair, force_link_up;
	logic twisted_pair_tx_disable, correction_disable_a;
	logic led_output_first, led_output_second;
	logic [3:0] avs_byteenable = 4'hf;
	logic [4:0] avs_address;
	logic [6:0] f;
	logic [31:0] avs_writedata, avs_readdata, obs_v, exp_v, got_v;
	logic [31:0] q[$];
	logic [31:0] c1[4] = '{32'h0, 32'h0, 32'h4000, 32'h100};
	logic [31:0] c2[4] = '{32'h100, 32'h0, 32'h100, 32'hffff};
	logic [7:0] ep[4] = '{8'h20, 8'h61, 8'h42, 8'h9f};
	int error_cnt = 0, checks = 0, n, g;
`define CHK(s, e, v) \
	begin \
		checks++; \
		if ((e) !== (v)) \
		begin \
			error_cnt++; \
			$display("[ERR] %s exp %h got %h", s, e, v); \
		end \
	end
	mcfg_top mcfg_top_inst(.*);
	mcfg_host mcfg_host_inst(.*);
	always #20 clk = ~clk;
	always @(posedge clk)
		if ((avs_read && !avs_waitrequest) || obs_p)
		begin
			exp_v = q.pop_front();
			got_v = avs_read ? avs_readdata : obs_v;
			`CHK(avs_read ? "readdata" : "pins", exp_v, got_v)
		end
	task automatic wx(input logic [4:0] a, input logic [31:0] d);
		mcfg_host_inst.xfer(1'b1, a, d);
	endtask
	task automatic rx(input logic [4:0] a, input logic [31:0] e);
		q.push_back(e);
		mcfg_host_inst.xfer(1'b0, a, 32'h0);
	endtask
	task automatic put(input logic [31:0] e, input logic [31:0] v);
		q.push_back(e);
		obs_v <= v;
		obs_p <= 1'b1;
		@(posedge clk);
		obs_p <= 1'b0;
	endtask
	task automatic pins(input logic [7:0] e);
		repeat (3) @(posedge clk);
		put({24'h0, e}, {24'h0, full_duplex, tx_loopback, tx_to_pair,
			force_link_up, twisted_pair_tx_disable, correction_disable_a,
			led_output_second, led_output_first});
	endtask
	task automatic gap(input int e);
		tx_end <= 1'b1;
		@(posedge clk);
		tx_end <= 1'b0;
		n = 0;
		do
		begin
			n++;
			@(posedge clk);
		end
		while ((tx_gap_busy || n < 3) && n < 2000);
		put(32'h1, {31'h0, n >= e * 10 - 10 && n <= e * 10 + 3});
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(93));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rx(5'h08, 32'h100);
		rx(5'h0c, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			f = i == 0 ? 7'h15 : i == 1 ? 7'h12 : 7'($urandom);
			wx(5'h08, i == 0 ? 32'h100 : 32'h0);
			wx(5'h04, {31'h0, i == 0});
			wx(5'h00, {24'h0, 1'b1, f});
			rx(5'h00, {25'h0, f});
			g = f + (i == 0 ? 3 : 6);
			rx(5'h14, 32'h100 | 32'(g));
			gap(g);
		end
		for (int i = 0; i < 4; i++)
		begin
			wx(5'h04, {31'h0, i == 3});
			wx(5'h08, c1[i]);
			wx(5'h0c, c2[i]);
			wx(5'h10, 32'(i));
			pins(ep[i]);
		end
		rx(5'h0c, 32'h6500);
		rx(5'h10, 32'h3);
		wx(5'h1c, 32'hffff);
		rx(5'h1c, 32'h0);
		report_and_stop();
	end
endmodule
